// ---- rtl/vic_pkg.sv ----
// shared constants, types and vector table of the vectored interrupt controller
package vic_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 19;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VEC_W = 16;

  // ----------------------------------------------------------------
  // register map (word aligned byte offsets)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_REQUEST_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MASK_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PRIORITY_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;

  // control and status field positions
  localparam int CTRL_GLOBAL_EN_BIT = 0;
  localparam int STAT_GLOBAL_EN_BIT = 0;
  localparam int STAT_HIGH_SVC_BIT = 1;
  localparam int STAT_OFFER_BIT = 2;
  localparam int STAT_BREAK_PEND_BIT = 3;
  localparam int STAT_DEPTH_LSB = 8;
  localparam int STAT_DEPTH_W = 8;
  localparam int STAT_VECTOR_LSB = 16;

  // ----------------------------------------------------------------
  // reset values: every source masked and in the low group
  // ----------------------------------------------------------------
  localparam logic [NUM_SRC-1:0] REQUEST_RESET = 19'h00000;
  localparam logic [NUM_SRC-1:0] MASK_RESET = 19'h7FFFF;
  localparam logic [NUM_SRC-1:0] PRIORITY_RESET = 19'h7FFFF;
  localparam logic GLOBAL_EN_RESET = 1'h0;

  // priority flag value that places a source in the high group
  localparam logic GROUP_HIGH = 1'h0;

  // ----------------------------------------------------------------
  // vector addresses, index equals default rank
  // ----------------------------------------------------------------
  localparam logic [VEC_W-1:0] VECTOR_TABLE [NUM_SRC] = '{
    16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h0010,
    16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h0028, 16'h002A,
    16'h002C, 16'h002E, 16'h0030, 16'h0032, 16'h0034, 16'h003A,
    16'h003C
  };
  localparam logic [VEC_W-1:0] BREAK_VECTOR = 16'h003E;

  // ----------------------------------------------------------------
  // request inputs; first field is the msb, so rank 0 lands on bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic adc_done_irq;
    logic muldiv_done_irq;
    logic narrow_timer_b_irq;
    logic narrow_timer_a_irq;
    logic serial_tx_done_irq;
    logic serial_rx_done_irq;
    logic serial_rx_error_irq;
    logic wide_timer_b_irq;
    logic wide_timer_a_irq;
    logic updown_timer_match_c_irq;
    logic updown_timer_match_b_irq;
    logic updown_timer_match_a_irq;
    logic updown_timer_underflow_irq;
    logic ext_pin_irq_5;
    logic ext_pin_irq_3;
    logic ext_pin_irq_2;
    logic ext_pin_irq_1;
    logic ext_pin_irq_0;
    logic low_voltage_irq;
  } irq_sources_t;

  // what is being offered to the cpu
  typedef enum logic [1:0] {
    OFFER_IDLE = 2'b00,
    OFFER_MASKABLE = 2'b01,
    OFFER_BREAK = 2'b10
  } offer_t;

  // vector lookup; unlisted slots are never produced
  function automatic logic [VEC_W-1:0] vector_of(input logic [IDX_W-1:0] idx);
    logic [VEC_W-1:0] v;
    v = BREAK_VECTOR;
    if (idx < IDX_W'(NUM_SRC)) begin
      v = VECTOR_TABLE[idx];
    end
    return v;
  endfunction

endpackage

// ---- rtl/rank_resolver.sv ----
// fixed-rank resolver: the lowest set index wins
`timescale 1ns/1ps
`default_nettype none
module rank_resolver #(
  parameter int N = 19,
  parameter int IDX_W = 5
) (
  input wire logic [N-1:0] i_candidates,
  output logic o_found,
  output logic [IDX_W-1:0] o_index
);

  // ----------------------------------------------------------------
  // scan from the top so the last hit is the lowest index
  // ----------------------------------------------------------------
  always_comb begin
    o_found = 1'b0;
    o_index = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (i_candidates[k]) begin
        o_found = 1'b1;
        o_index = IDX_W'(k);
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/vectored_interrupt_controller.sv ----
// vectored interrupt controller: request flags, masking, two groups, nesting, vectors
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - a set mask flag keeps its source from ever being offered to the cpu.
// - each source's priority flag puts it in the high or the low group.
// - during a low-group service, a high-group request nests ahead of it.
// - simultaneous same-group requests are taken one at a time by rank 0 to 18.
// - any unmasked pending request raises standby release for stop and halt.
// - nineteen maskable inputs: five pin edge sources and fourteen internal ones.
// - a breakpoint instruction raises its own vectored software interrupt.
// - breakpoint is taken with global enable off and ignores groups and nesting.
// - low voltage detection has rank 0 and vector 0004H.
// - the five pin edge sources have ranks 1 to 5, vectors 0006H to 0010H.
// - up/down timer underflow and three matches: ranks 6 to 9, 0016H to 001CH.
// - the two wide timer sources have ranks 10 and 11, first at 0028H.
// - serial error, receive and transmit: ranks 12 to 14, 002CH to 0030H.
// - the two narrow timer matches have ranks 15 and 16, 0032H and 0034H.
// - multiply/divide completion has rank 17 and vector 003AH.
// - conversion completion has the lowest rank, 18, and vector 003CH.
// - within a group, rank 0 beats every other rank and rank 18 loses to all.
// - a request flag sets on its source and clears when the cpu acknowledges.
// - the breakpoint interrupt vectors to 003EH.
module vectored_interrupt_controller
  import vic_pkg::*;
#(
  parameter int NEST_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire irq_sources_t i_irq,
  input wire logic i_brk,
  input wire logic i_int_ack,
  input wire logic i_reti,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_int_req,
  output logic [VEC_W-1:0] o_int_vector,
  output logic o_int_is_break,
  output logic o_standby_release
);

  localparam int DEPTH_W = $clog2(NEST_DEPTH + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] req_flags;
  logic [NUM_SRC-1:0] mask_flags;
  logic [NUM_SRC-1:0] prio_low;
  logic global_en;
  logic brk_pending;
  logic [NEST_DEPTH-1:0] svc_stack;
  logic [DEPTH_W-1:0] svc_depth;
  offer_t offer;
  logic [IDX_W-1:0] offer_src;

  logic [NUM_SRC-1:0] src_pulses;
  logic [NUM_SRC-1:0] eligible;
  logic [NUM_SRC-1:0] elig_high;
  logic [NUM_SRC-1:0] elig_low;
  logic high_in_service;
  logic high_found;
  logic low_found;
  logic [IDX_W-1:0] high_idx;
  logic [IDX_W-1:0] low_idx;
  logic ack_maskable;
  logic ack_break;
  logic wr_request;
  logic wr_mask;
  logic wr_priority;
  logic wr_control;
  offer_t next_offer;
  logic [IDX_W-1:0] next_offer_src;
  logic [NUM_SRC-1:0] next_req_flags;
  logic [DATA_W-1:0] next_rd_data;

  // ----------------------------------------------------------------
  // source mapping and register decode
  // ----------------------------------------------------------------
  // struct packing places rank 0 on bit 0, rank 18 on bit 18
  assign src_pulses = i_irq;
  assign wr_request = i_wr_en && (i_addr == REG_REQUEST_FLAGS);
  assign wr_mask = i_wr_en && (i_addr == REG_MASK_FLAGS);
  assign wr_priority = i_wr_en && (i_addr == REG_PRIORITY_FLAGS);
  assign wr_control = i_wr_en && (i_addr == REG_CONTROL);

  // acknowledges refer to what was on the output in this cycle
  assign ack_maskable = i_int_ack && (offer == OFFER_MASKABLE);
  assign ack_break = i_int_ack && (offer == OFFER_BREAK);

  // ----------------------------------------------------------------
  // eligibility and group blocking
  // ----------------------------------------------------------------
  // top of the service stack is the group of the innermost service
  assign high_in_service = (svc_depth != '0) && (svc_stack[0] == GROUP_HIGH);

  // masked or globally disabled requests never compete
  assign eligible = req_flags & ~mask_flags & {NUM_SRC{global_en}};
  assign elig_high = eligible & ~prio_low;
  // a high service in progress holds the whole low group back
  assign elig_low = eligible & prio_low & {NUM_SRC{~high_in_service}};

  rank_resolver #(
    .N(NUM_SRC),
    .IDX_W(IDX_W)
  ) u_high_resolver (
    .i_candidates(elig_high),
    .o_found(high_found),
    .o_index(high_idx)
  );

  rank_resolver #(
    .N(NUM_SRC),
    .IDX_W(IDX_W)
  ) u_low_resolver (
    .i_candidates(elig_low),
    .o_found(low_found),
    .o_index(low_idx)
  );

  // ----------------------------------------------------------------
  // offer selection
  // ----------------------------------------------------------------
  // after an acknowledge the offer drops for one cycle, so the cpu
  // never sees the stale winner a second time
  always_comb begin
    next_offer = OFFER_IDLE;
    next_offer_src = offer_src;
    case (offer)
      OFFER_IDLE, OFFER_MASKABLE, OFFER_BREAK: begin
        if (i_int_ack) begin
          next_offer = OFFER_IDLE;
        end else if (brk_pending) begin
          next_offer = OFFER_BREAK;
        end else if (high_found) begin
          next_offer = OFFER_MASKABLE;
          next_offer_src = high_idx;
        end else if (low_found) begin
          next_offer = OFFER_MASKABLE;
          next_offer_src = low_idx;
        end
      end
      default: begin
        next_offer = OFFER_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      offer <= OFFER_IDLE;
      offer_src <= '0;
    end else begin
      offer <= next_offer;
      offer_src <= next_offer_src;
    end
  end

  // ----------------------------------------------------------------
  // cpu side outputs
  // ----------------------------------------------------------------
  // vector follows the winner each cycle and is kept once the request drops, so the ack cycle sees it
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_int_req <= 1'b0;
      o_int_vector <= '0;
      o_int_is_break <= 1'b0;
    end else begin
      o_int_req <= (next_offer != OFFER_IDLE);
      o_int_is_break <= (next_offer == OFFER_BREAK);
      if (next_offer == OFFER_BREAK) begin
        o_int_vector <= BREAK_VECTOR;
      end else if (next_offer == OFFER_MASKABLE) begin
        o_int_vector <= vector_of(next_offer_src);
      end
    end
  end

  // wake-up ignores global enable and groups: a halted core must resume
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_standby_release <= 1'b0;
    end else begin
      o_standby_release <= |(req_flags & ~mask_flags);
    end
  end

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // software write, then acknowledge clear, then source set: set wins
  always_comb begin
    next_req_flags = req_flags;
    if (wr_request) begin
      next_req_flags = i_wr_data[NUM_SRC-1:0];
    end
    if (ack_maskable) begin
      next_req_flags[offer_src] = 1'b0;
    end
    next_req_flags = next_req_flags | src_pulses;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_flags <= REQUEST_RESET;
    end else begin
      req_flags <= next_req_flags;
    end
  end

  // ----------------------------------------------------------------
  // mask and priority flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_flags <= MASK_RESET;
      prio_low <= PRIORITY_RESET;
    end else begin
      if (wr_mask) begin
        mask_flags <= i_wr_data[NUM_SRC-1:0];
      end
      if (wr_priority) begin
        prio_low <= i_wr_data[NUM_SRC-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // global enable
  // ----------------------------------------------------------------
  // any acknowledge disables further interrupts until software
  // re-enables; hardware clear wins over a write in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      global_en <= GLOBAL_EN_RESET;
    end else if (i_int_ack && (offer != OFFER_IDLE)) begin
      global_en <= 1'b0;
    end else if (wr_control) begin
      global_en <= i_wr_data[CTRL_GLOBAL_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // breakpoint request
  // ----------------------------------------------------------------
  // the instruction pulse is kept until taken; a new pulse wins over
  // the acknowledge clear
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brk_pending <= 1'b0;
    end else if (i_brk) begin
      brk_pending <= 1'b1;
    end else if (ack_break) begin
      brk_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // service nesting stack
  // ----------------------------------------------------------------
  // one bit per nested maskable service, top at bit 0; breakpoint
  // services never enter it. limitation: nesting past NEST_DEPTH
  // loses the oldest entry
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      svc_stack <= '0;
      svc_depth <= '0;
    end else if (ack_maskable) begin
      svc_stack <= {svc_stack[NEST_DEPTH-2:0], prio_low[offer_src]};
      if (svc_depth != DEPTH_W'(NEST_DEPTH)) begin
        svc_depth <= svc_depth + DEPTH_W'(1);
      end
    end else if (i_reti && (svc_depth != '0)) begin
      svc_stack <= {1'b0, svc_stack[NEST_DEPTH-1:1]};
      svc_depth <= svc_depth - DEPTH_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // unmapped addresses read as zero
  always_comb begin
    next_rd_data = '0;
    case (i_addr)
      REG_REQUEST_FLAGS: begin
        next_rd_data[NUM_SRC-1:0] = req_flags;
      end
      REG_MASK_FLAGS: begin
        next_rd_data[NUM_SRC-1:0] = mask_flags;
      end
      REG_PRIORITY_FLAGS: begin
        next_rd_data[NUM_SRC-1:0] = prio_low;
      end
      REG_CONTROL: begin
        next_rd_data[CTRL_GLOBAL_EN_BIT] = global_en;
      end
      REG_STATUS: begin
        next_rd_data[STAT_GLOBAL_EN_BIT] = global_en;
        next_rd_data[STAT_HIGH_SVC_BIT] = high_in_service;
        next_rd_data[STAT_OFFER_BIT] = o_int_req;
        next_rd_data[STAT_BREAK_PEND_BIT] = brk_pending;
        next_rd_data[STAT_DEPTH_LSB +: STAT_DEPTH_W] = STAT_DEPTH_W'(svc_depth);
        next_rd_data[STAT_VECTOR_LSB +: VEC_W] = o_int_vector;
      end
      default: begin
        next_rd_data = '0;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= '0;
    end else if (i_rd_en) begin
      o_rd_data <= next_rd_data;
    end else begin
      o_rd_data <= '0;
    end
  end

endmodule
`default_nettype wire

// ---- tb/vic_asserts.sv ----
// port-level checks for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_asserts
  import vic_pkg::*;
#(
  parameter int NEST_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_brk,
  input wire logic i_int_ack,
  input wire logic i_rd_en,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic o_int_req,
  input wire logic [VEC_W-1:0] o_int_vector,
  input wire logic o_int_is_break,
  input wire logic o_standby_release
);
  // ----------------------------------------------------------------
  // single domain, so one clock and one disable for all
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  // read data is zero except in the cycle after a read strobe
  a_rd_data_idle: assert property (!$past(i_rd_en) |-> o_rd_data == '0)
    else $error("read data not zero outside the read cycle");
  a_break_vector: assert property (
    o_int_is_break |-> o_int_req && o_int_vector == 16'h003E)
    else $error("breakpoint offered with a wrong vector");
  a_ack_drops_req: assert property (
    i_int_ack && o_int_req |=> !o_int_req)
    else $error("request still up after acknowledge");
  // empty slots must never reach the cpu
  a_no_empty_slot: assert property (
    o_int_req |-> !(o_int_vector inside {16'h000E, 16'h0012, 16'h0014, 16'h001E, 16'h0020,
                                         16'h0022, 16'h0024, 16'h0026, 16'h0036, 16'h0038}))
    else $error("empty vector slot offered");
  a_offer_holds: assert property (
    o_int_req && !i_int_ack |=> o_int_req)
    else $error("offer withdrawn before acknowledge");
  a_break_offered: assert property (
    i_brk |-> ##[1:3] (o_int_req && o_int_is_break))
    else $error("breakpoint not offered in time");
  a_offer_wakes: assert property (
    o_int_req && !o_int_is_break |-> o_standby_release)
    else $error("maskable offer without standby release");
  a_reset_quiet: assert property (
    $rose(i_rst_b) |-> !o_int_req && !o_int_is_break && !o_standby_release)
    else $error("outputs not quiet after reset");

  // main scenarios reached
  c_break: cover property (o_int_req && o_int_is_break && i_int_ack);
  c_maskable: cover property (o_int_req && !o_int_is_break && i_int_ack);
  c_wake: cover property (o_standby_release && !o_int_req);
endmodule

bind vectored_interrupt_controller vic_asserts #(.NEST_DEPTH(NEST_DEPTH)) u_vic_asserts (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_brk(i_brk), .i_int_ack(i_int_ack),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_int_req(o_int_req), .o_int_vector(o_int_vector),
  .o_int_is_break(o_int_is_break), .o_standby_release(o_standby_release));
`default_nettype wire

// ---- tb/cpu_model.sv ----
// behavioural cpu core that acknowledges offers, promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module cpu_model
  import vic_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_ack_en,
  input wire logic [3:0] i_delay,
  input wire logic i_int_req,
  input wire logic [VEC_W-1:0] i_int_vector,
  input wire logic i_int_is_break,
  output logic o_int_ack,
  output logic [VEC_W-1:0] o_seen_vec,
  output logic o_seen_break
);
  logic [3:0] wait_cnt;

  // how long the current offer has stood; lets the cpu lag on purpose
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_cnt <= '0;
    end else if (!i_int_req || o_int_ack) begin
      wait_cnt <= '0;
    end else if (wait_cnt != 4'hF) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // one-cycle acknowledge; vector taken at the edge the controller sees it,
  // since the winner may still change while the ack is on its way
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_int_ack <= 1'b0;
      o_seen_vec <= '0;
      o_seen_break <= 1'b0;
    end else begin
      o_int_ack <= i_ack_en && i_int_req && !o_int_ack && (wait_cnt >= i_delay);
      if (o_int_ack && i_int_req) begin
        o_seen_vec <= i_int_vector;
        o_seen_break <= i_int_is_break;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vic_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  irq_sources_t i_irq = '0;
  logic i_brk = 1'b0;
  logic i_reti = 1'b0;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wr_data = '0;
  logic [DATA_W-1:0] o_rd_data;
  logic [DATA_W-1:0] rd_val;
  logic i_int_ack, o_int_req, o_int_is_break, o_standby_release, seen_break;
  logic [VEC_W-1:0] o_int_vector, seen_vec;
  logic ack_en = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  int err_total = 0;
  int samples_checked = 0;
  // expected vector by default rank, kept apart from the package table
  logic [VEC_W-1:0] exp_vec [19] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C,
    16'h0010, 16'h0016, 16'h0018, 16'h001A, 16'h001C, 16'h0028, 16'h002A, 16'h002C,
    16'h002E, 16'h0030, 16'h0032, 16'h0034, 16'h003A, 16'h003C};

  initial forever #4 i_sys_clk = ~i_sys_clk;

  vectored_interrupt_controller #(.NEST_DEPTH(8)) DUT (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_irq(i_irq), .i_brk(i_brk),
    .i_int_ack(i_int_ack), .i_reti(i_reti), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_int_req(o_int_req),
    .o_int_vector(o_int_vector), .o_int_is_break(o_int_is_break),
    .o_standby_release(o_standby_release));

  cpu_model cpu (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_ack_en(ack_en), .i_delay(ack_delay),
    .i_int_req(o_int_req), .i_int_vector(o_int_vector), .i_int_is_break(o_int_is_break),
    .o_int_ack(i_int_ack), .o_seen_vec(seen_vec), .o_seen_break(seen_break));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus and cpu-side actions, all launched right after a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    #1 rd_val = o_rd_data;
  endtask

  task automatic pulse_irq(input logic [NUM_SRC-1:0] bits);
    @(posedge i_sys_clk);
    i_irq <= irq_sources_t'(bits);
    @(posedge i_sys_clk);
    i_irq <= '0;
  endtask

  task automatic pulse_brk();
    @(posedge i_sys_clk);
    i_brk <= 1'b1;
    @(posedge i_sys_clk);
    i_brk <= 1'b0;
  endtask

  // maskable service ends; the breakpoint's return never pulses this
  task automatic reti();
    @(posedge i_sys_clk);
    i_reti <= 1'b1;
    @(posedge i_sys_clk);
    i_reti <= 1'b0;
  endtask

  // bounded wait for the cpu to take an offer, then compare what it fetched
  task automatic wait_ack(input logic [VEC_W-1:0] v, input logic b);
    bit found;
    found = 1'b0;
    for (int k = 0; k < 60 && !found; k++) begin
      @(negedge i_sys_clk);
      found = (i_int_ack === 1'b1);
    end
    if (!found) begin
      err_total++;
      complete_run();
    end
    @(negedge i_sys_clk);
    check(seen_vec, v);
    check(seen_break, b);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge i_sys_clk);
      check(o_int_req, 1'b0);
    end
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_total++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd(REG_MASK_FLAGS);
    check(rd_val, 32'h0007FFFF);
    rd(REG_PRIORITY_FLAGS);
    check(rd_val, 32'h0007FFFF);
    rd(8'h14);
    check(rd_val, 32'h00000000);
    // masked source: flagged but never offered, no wake-up
    wr(REG_MASK_FLAGS, 32'h00000010);
    wr(REG_CONTROL, 32'h00000001);
    pulse_irq(19'h00010);
    quiet(8);
    check(o_standby_release, 1'b0);
    rd(REG_REQUEST_FLAGS);
    check(rd_val, 32'h00000010);
    wr(REG_MASK_FLAGS, 32'h00000000);
    @(posedge i_sys_clk) ack_en <= 1'b1;
    wait_ack(16'h000C, 1'b0);
    reti();
    rd(REG_REQUEST_FLAGS);
    check(rd_val, 32'h00000000);
    rd(REG_CONTROL);
    check(rd_val, 32'h00000000);
    // ack cleared global enable: pending but held back, still wakes
    pulse_irq(19'h00001);
    quiet(6);
    check(o_standby_release, 1'b1);
    wr(REG_CONTROL, 32'h00000001);
    wait_ack(16'h0004, 1'b0);
    reti();
    // breakpoint taken with global enable off
    pulse_brk();
    wait_ack(16'h003E, 1'b1);
    // all nineteen at once, slow cpu: taken in rank order
    @(posedge i_sys_clk) ack_delay <= 4'h3;
    wr(REG_CONTROL, 32'h00000001);
    pulse_irq(19'h7FFFF);
    for (int i = 0; i < NUM_SRC; i++) begin
      wait_ack(exp_vec[i], 1'b0);
      reti();
      wr(REG_CONTROL, 32'h00000001);
    end
    // nesting: rank 2 in the high group interrupts a low service
    @(posedge i_sys_clk) ack_delay <= 4'h0;
    wr(REG_PRIORITY_FLAGS, 32'h0007FFFB);
    pulse_irq(19'h40000);
    wait_ack(16'h003C, 1'b0);
    wr(REG_CONTROL, 32'h00000001);
    pulse_irq(19'h00004);
    wait_ack(16'h0008, 1'b0);
    // high service blocks the low group until it returns
    wr(REG_CONTROL, 32'h00000001);
    pulse_irq(19'h10000);
    quiet(6);
    // status: enable on, high in service, no offer, depth 2, last vector kept
    rd(REG_STATUS);
    check(rd_val, 32'h00080203);
    reti();
    wait_ack(16'h0034, 1'b0);
    reti();
    reti();
    complete_run();
  end
endmodule
`default_nettype wire
